// file: dv/rtc_alarm_time_of_day_match_test.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_time_of_day_match_test;
   import rtcatm_pkg::*;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         uvlo = 1'b1;
   logic         f24 = 1'b1;
   logic         bcd = 1'b0;
   rtcatm_live_t live = '0;
   rtcatm_req_t  req;
   logic         commit;
   logic         refresh;
   logic [7:0]   rdata;
   logic         rvalid;
   logic [1:0]   ev;
   logic [5:0]   fm;
   int           failures = 0;
   int           tests_run = 0;
   int           cycles = 0;
   logic [7:0]   addrs [6] = '{8'h0E, 8'h0F, 8'h10, 8'h15, 8'h16, 8'h17};

   always #12.5 clk = ~clk;

   rtcatm_top #(.NUM_CH(2)) DUT (
      .clk_i(clk), .sys_rst_i(rst), .backup_uvlo_i(uvlo), .req_i(req),
      .write_commit_request_i(commit), .read_refresh_request_i(refresh),
      .rdata_o(rdata), .rvalid_o(rvalid), .live_i(live),
      .live_h_counter_format_24_i(f24), .bcd_format_i(bcd),
      .alarm_event_o(ev), .field_match_o(fm));

   rtcatm_host host (
      .clk_i(clk), .f24_i(f24), .bcd_i(bcd), .rdata_i(rdata),
      .rvalid_i(rvalid), .req_o(req), .commit_o(commit),
      .refresh_o(refresh));

   task automatic give_verdict;
      if (failures == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   // whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         failures = failures + 1;
         give_verdict();
      end
   end

   task automatic check(input string n, input logic [7:0] e,
                        input logic [7:0] g);
      tests_run = tests_run + 1;
      if (g !== e)
      begin
         failures = failures + 1;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : check

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      check("rdata", e, d);
   endtask : rchk

   // counts pulses over a window long enough for the one-cycle latency
   task automatic live_ev(input logic [6:0] s, input logic [6:0] m,
                          input logic [5:0] h, input logic p,
                          input int ch, input logic [7:0] e);
      logic [7:0] n;
      n = 8'h00;
      @(negedge clk);
      live <= '{s, m, h, p};
      repeat (6)
      begin
         @(negedge clk);
         n = n + {7'h00, ev[ch]};
      end
      check("alarm_event", e, n);
   endtask : live_ev

   task automatic t_uvlo;
      host.wr(8'h0E, 8'h85);
      host.strobe(1'b1, 1'b1);
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      host.strobe(1'b0, 1'b1);
      rchk(8'h0E, 8'h85);
      uvlo = 1'b1;
      @(negedge clk);
      uvlo = 1'b0;
      host.strobe(1'b0, 1'b1);
      foreach (addrs[i])
         rchk(addrs[i], 8'h00);
   endtask : t_uvlo

   task automatic t_buffer;
      host.wr(8'h0F, 8'h3A);
      host.strobe(1'b0, 1'b1);
      rchk(8'h0F, 8'h00);
      host.strobe(1'b1, 1'b0);
      rchk(8'h0F, 8'h00);
      host.strobe(1'b0, 1'b1);
      rchk(8'h0F, 8'h3A);
      host.wr(8'h20, 8'hFF);
      rchk(8'h20, 8'h00);
   endtask : t_buffer

   task automatic t_sec_min;
      host.wr(8'h0E, 8'h85);
      host.wr(8'h0F, 8'h9A);
      host.strobe(1'b1, 1'b0);
      live_ev(7'h05, 7'h1A, 6'h00, 1'b0, 0, 8'h01);
      check("field_match", 8'h03, {6'h00, fm[1:0]});
      live_ev(7'h06, 7'h1B, 6'h00, 1'b0, 0, 8'h00);
      host.wr(8'h0F, 8'h1A);
      host.strobe(1'b1, 1'b0);
      live_ev(7'h05, 7'h1B, 6'h00, 1'b0, 0, 8'h01);
      host.wr(8'h0E, 8'h05);
      host.strobe(1'b1, 1'b0);
      live_ev(7'h06, 7'h1B, 6'h00, 1'b0, 0, 8'h00);
      live_ev(7'h05, 7'h1A, 6'h00, 1'b0, 0, 8'h00);
   endtask : t_sec_min

   task automatic t_hours;
      @(negedge clk);
      f24 = 1'b0;
      host.wr(8'h17, 8'hC7);
      host.strobe(1'b1, 1'b0);
      live_ev(7'h00, 7'h00, 6'h07, 1'b0, 1, 8'h00);
      live_ev(7'h00, 7'h00, 6'h07, 1'b1, 1, 8'h01);
      check("field_match", 8'h04, {5'h00, fm[5:3]});
      live_ev(7'h00, 7'h00, 6'h08, 1'b1, 1, 8'h00);
      f24 = 1'b1;
      live_ev(7'h00, 7'h00, 6'h07, 1'b0, 1, 8'h01);
      bcd = 1'b1;
      host.wr(8'h17, 8'h92);
      host.strobe(1'b1, 1'b0);
      live_ev(7'h00, 7'h00, 6'h12, 1'b0, 1, 8'h01);
   endtask : t_hours

   initial
   begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      uvlo = 1'b0;
      t_uvlo();
      t_buffer();
      t_sec_min();
      t_hours();
      give_verdict();
   end
endmodule : rtc_alarm_time_of_day_match_test
`default_nettype wire

// file: dv/rtcatm_host.sv
`timescale 1ns/1ps
`default_nettype none
module rtcatm_host
   import rtcatm_pkg::*;
(
   // clock and format
   input  wire logic       clk_i,
   input  wire logic       f24_i,
   input  wire logic       bcd_i,
   // register bus
   input  wire logic [7:0] rdata_i,
   input  wire logic       rvalid_i,
   output var rtcatm_req_t req_o,
   output logic            commit_o,
   output logic            refresh_o
);
   initial
   begin
      req_o = '0;
      commit_o = 1'b0;
      refresh_o = 1'b0;
   end

   // host never sends an hours value outside its mode, save hours 00 in 12h BCD
   function automatic logic live_h_counter_ok(input logic [5:0] h);
      logic [5:0] top;
      top = f24_i ? (bcd_i ? 6'h23 : 6'h17)
                  : (bcd_i ? 6'h12 : 6'h0C);
      live_h_counter_ok = h <= top && (!bcd_i || h[3:0] <= 4'h9)
                && (f24_i || bcd_i || h != 6'h00);
   endfunction : live_h_counter_ok

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      if ((a == 8'h10 || a == 8'h17) && !live_h_counter_ok(d[5:0]))
         return;
      req_o <= '{1'b1, 1'b0, a, d};
      @(negedge clk_i);
      req_o <= '0;
   endtask : wr

   // answer stands only in the cycle right after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      req_o <= '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk_i);
      d = rvalid_i ? rdata_i : 8'hXX;
      req_o <= '0;
   endtask : rd

   task automatic strobe(input logic c, input logic r);
      @(negedge clk_i);
      commit_o <= c;
      refresh_o <= r;
      @(negedge clk_i);
      commit_o <= 1'b0;
      refresh_o <= 1'b0;
   endtask : strobe
endmodule : rtcatm_host
`default_nettype wire

// file: logic/rtcatm_defines.svh
`ifndef RTCATM_DEFINES_SVH
`define RTCATM_DEFINES_SVH

// register addresses
`define RTCATM_A1_SEC_ADDR  8'h0E
`define RTCATM_A1_MIN_ADDR  8'h0F
`define RTCATM_A1_LIVE_H_COUNTER_ADDR 8'h10
`define RTCATM_A2_SEC_ADDR  8'h15
`define RTCATM_A2_MIN_ADDR  8'h16
`define RTCATM_A2_LIVE_H_COUNTER_ADDR 8'h17
`define RTCATM_REG_RESET    8'h00
// field positions
`define RTCATM_EN_BIT       7
`define RTCATM_HALF_BIT     6
`define RTCATM_SM_MSB       6
`define RTCATM_H_MSB        5
`define RTCATM_H_TENS_LSB   4
`define RTCATM_H_UNITS_MSB  3
// twelve o'clock, in both encodings
`define RTCATM_H12_BIN      6'h0C
`define RTCATM_H12_BCD      6'h12
`define RTCATM_NUM_CH       2

`endif

// file: logic/rtcatm_match.sv
`include "rtcatm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rtcatm_match
   import rtcatm_pkg::*;
(
   // clock and reset
   input  wire logic          clk_i,
   input  wire logic          sys_rst_i,
   // compare values and live time
   input  wire rtcatm_alarm_t alarm_i,
   input  wire rtcatm_live_t  live_i,
   input  wire logic          live_h_counter_format_24_i,
   input  wire logic          bcd_format_i,
   // results
   output logic [2:0]         field_match_o,
   output logic               alarm_event_o
);
   typedef struct packed {
      logic [2:0] match;
      logic       hit;
      logic       event_p;
   } rtcatm_mstate_t;

   rtcatm_mstate_t s_q, s_d;
   logic s_en, m_en, h_en, s_eq, m_eq, h_eq, any_en, all_ok;

   // in 12-live_h_counter mode the half-day bit must match as well
   function automatic logic live_h_counter_eq(input logic [7:0] a,
                                    input rtcatm_live_t l,
                                    input logic f24);
      live_h_counter_eq = (a[`RTCATM_H_MSB:0] == l.live_h_counter) &&
                (f24 || (a[`RTCATM_HALF_BIT] == l.pm));
   endfunction : live_h_counter_eq

   always_comb
   begin
      s_en   = alarm_i.sec[`RTCATM_EN_BIT];
      m_en   = alarm_i.min[`RTCATM_EN_BIT];
      h_en   = alarm_i.live_h_counter[`RTCATM_EN_BIT];
      s_eq   = alarm_i.sec[`RTCATM_SM_MSB:0] == live_i.sec;
      m_eq   = alarm_i.min[`RTCATM_SM_MSB:0] == live_i.min;
      h_eq   = live_h_counter_eq(alarm_i.live_h_counter, live_i, live_h_counter_format_24_i);
      any_en = s_en | m_en | h_en;
      all_ok = any_en && (!s_en || s_eq) && (!m_en || m_eq)
               && (!h_en || h_eq);
      s_d         = s_q;
      s_d.match   = {h_en & h_eq, m_en & m_eq, s_en & s_eq};
      s_d.hit     = all_ok;
      s_d.event_p = all_ok && !s_q.hit;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign field_match_o = s_q.match;
   assign alarm_event_o = s_q.event_p;

   // encoding is transparent to an equality compare
   logic unused_bcd;
   assign unused_bcd = bcd_format_i;

   property p_event_once;
      @(posedge clk_i) disable iff (sys_rst_i)
      alarm_event_o |=> !alarm_event_o;
   endproperty
   a_event_once: assert property (p_event_once)
      else $error("alarm event lasted more than one cycle");

   property p_no_en_no_event;
      @(posedge clk_i) disable iff (sys_rst_i)
      !(alarm_i.sec[`RTCATM_EN_BIT] | alarm_i.min[`RTCATM_EN_BIT] |
        alarm_i.live_h_counter[`RTCATM_EN_BIT]) |=> !s_q.hit;
   endproperty
   a_no_en_no_event: assert property (p_no_en_no_event)
      else $error("hit with no field enabled");

   property p_sec_match;
      @(posedge clk_i) disable iff (sys_rst_i)
      (alarm_i.sec[`RTCATM_EN_BIT] &&
       alarm_i.sec[`RTCATM_SM_MSB:0] == live_i.sec) |=>
      field_match_o[0];
   endproperty
   a_sec_match: assert property (p_sec_match)
      else $error("seconds match missed");

   property p_min_off;
      @(posedge clk_i) disable iff (sys_rst_i)
      !alarm_i.min[`RTCATM_EN_BIT] |=> !field_match_o[1];
   endproperty
   a_min_off: assert property (p_min_off)
      else $error("disabled minutes matched");

   property p_live_h_counter_pm;
      @(posedge clk_i) disable iff (sys_rst_i)
      (!live_h_counter_format_24_i &&
       alarm_i.live_h_counter[`RTCATM_HALF_BIT] != live_i.pm) |=>
      !field_match_o[2];
   endproperty
   a_live_h_counter_pm: assert property (p_live_h_counter_pm)
      else $error("live_h_counter matched across half day");

   property p_live_h_counter_24;
      @(posedge clk_i) disable iff (sys_rst_i)
      (live_h_counter_format_24_i && alarm_i.live_h_counter[`RTCATM_EN_BIT] &&
       alarm_i.live_h_counter[`RTCATM_H_MSB:0] == live_i.live_h_counter) |=> field_match_o[2];
   endproperty
   a_live_h_counter_24: assert property (p_live_h_counter_24)
      else $error("24-live_h_counter match missed");

   c_event: cover property (@(posedge clk_i) alarm_event_o);
   c_pm: cover property (@(posedge clk_i)
      !live_h_counter_format_24_i && field_match_o[2]);
endmodule : rtcatm_match
`default_nettype wire

// file: logic/rtcatm_pkg.sv
`default_nettype none
package rtcatm_pkg;
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] live_h_counter;
   } rtcatm_alarm_t;

   typedef struct packed {
      logic [6:0] sec;
      logic [6:0] min;
      logic [5:0] live_h_counter;
      logic       pm;
   } rtcatm_live_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rtcatm_req_t;
endpackage : rtcatm_pkg
`default_nettype wire

// file: logic/rtcatm_top.sv
// Function
// - seconds field compares when bit 7 set
// - minutes field compares when bit 7 set
// - hours field compares when bit 7 set
// - writes land in holding buffer until commit
// - readback refreshes only on refresh request
// - half-day bit counts only in 12h mode
// - format control 1 means 24-live_h_counter hours
// - format bit picks binary or BCD encoding
`include "rtcatm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rtcatm_top
   import rtcatm_pkg::*;
#(
   parameter int NUM_CH = `RTCATM_NUM_CH
)
(
   // clock and resets
   input  wire logic               clk_i,
   input  wire logic               sys_rst_i,
   input  wire logic               backup_uvlo_i,
   // register access from the serial slave
   input  wire rtcatm_req_t        req_i,
   input  wire logic               write_commit_request_i,
   input  wire logic               read_refresh_request_i,
   output logic [7:0]              rdata_o,
   output logic                    rvalid_o,
   // live time and format
   input  wire rtcatm_live_t       live_i,
   input  wire logic               live_h_counter_format_24_i,
   input  wire logic               bcd_format_i,
   // alarm results
   output logic [NUM_CH-1:0]       alarm_event_o,
   output logic [NUM_CH*3-1:0]     field_match_o
);
   // only the undervoltage clears the buffers; sys_rst_i keeps them
   typedef struct packed {
      rtcatm_alarm_t [NUM_CH-1:0] hold;
      rtcatm_alarm_t [NUM_CH-1:0] active;
      rtcatm_alarm_t [NUM_CH-1:0] rback;
   } rtcatm_regs_t;

   typedef struct packed {
      logic [7:0] rdata;
      logic       rvalid;
   } rtcatm_bus_t;

   rtcatm_regs_t r_q, r_d;
   rtcatm_bus_t  b_q, b_d;
   logic [NUM_CH-1:0]   ev_w;
   logic [NUM_CH*3-1:0] fm_w;

   // returns channel*3+field, or all ones when unmapped
   function automatic logic [3:0] decode(input logic [7:0] a);
      case (a)
         `RTCATM_A1_SEC_ADDR:  decode = 4'h0;
         `RTCATM_A1_MIN_ADDR:  decode = 4'h1;
         `RTCATM_A1_LIVE_H_COUNTER_ADDR: decode = 4'h2;
         `RTCATM_A2_SEC_ADDR:  decode = 4'h3;
         `RTCATM_A2_MIN_ADDR:  decode = 4'h4;
         `RTCATM_A2_LIVE_H_COUNTER_ADDR: decode = 4'h5;
         default:              decode = 4'hF;
      endcase
   endfunction : decode

   function automatic logic [7:0] pick(input rtcatm_alarm_t a,
                                       input logic [1:0] f);
      case (f)
         2'h0:    pick = a.sec;
         2'h1:    pick = a.min;
         default: pick = a.live_h_counter;
      endcase
   endfunction : pick

   logic [3:0] idx;
   logic [1:0] fld;
   logic       ch;

   always_comb
   begin
      idx = decode(req_i.addr);
      ch  = (idx >= 4'h3);
      fld = ch ? 2'(idx - 4'h3) : idx[1:0];
      r_d = r_q;
      if (req_i.wr && idx != 4'hF)
      begin
         case (fld)
            2'h0:    r_d.hold[ch].sec  = req_i.wdata;
            2'h1:    r_d.hold[ch].min  = req_i.wdata;
            default: r_d.hold[ch].live_h_counter = req_i.wdata;
         endcase
      end
      // commit sees this cycle's write too, so nothing is lost
      if (write_commit_request_i)
         r_d.active = r_d.hold;
      if (read_refresh_request_i)
         r_d.rback = r_q.active;
      b_d.rvalid = req_i.rd;
      b_d.rdata  = `RTCATM_REG_RESET;
      if (req_i.rd && idx != 4'hF)
         b_d.rdata = pick(r_q.rback[ch], fld);
   end

   always_ff @(posedge clk_i or posedge backup_uvlo_i)
   begin
      if (backup_uvlo_i)
         r_q <= '0;
      else
         r_q <= r_d;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         b_q <= '0;
      else
         b_q <= b_d;
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         rtcatm_match u_match (
            .clk_i            (clk_i),
            .sys_rst_i        (sys_rst_i),
            .alarm_i          (r_q.active[g]),
            .live_i           (live_i),
            .live_h_counter_format_24_i (live_h_counter_format_24_i),
            .bcd_format_i     (bcd_format_i),
            .field_match_o    (fm_w[g*3 +: 3]),
            .alarm_event_o    (ev_w[g])
         );
      end
   endgenerate

   assign rdata_o       = b_q.rdata;
   assign rvalid_o      = b_q.rvalid;
   assign alarm_event_o = ev_w;
   assign field_match_o = fm_w;

   property p_hold_only;
      @(posedge clk_i) disable iff (backup_uvlo_i)
      !write_commit_request_i |=> r_q.active == $past(r_q.active);
   endproperty
   a_hold_only: assert property (p_hold_only)
      else $error("active changed without commit");

   property p_commit;
      @(posedge clk_i) disable iff (backup_uvlo_i)
      (req_i.wr && req_i.addr == `RTCATM_A1_SEC_ADDR &&
       write_commit_request_i)
      |=> r_q.active[0].sec == $past(req_i.wdata);
   endproperty
   a_commit: assert property (p_commit)
      else $error("commit lost same-cycle write");

   property p_frozen;
      @(posedge clk_i) disable iff (backup_uvlo_i)
      !read_refresh_request_i |=> r_q.rback == $past(r_q.rback);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("readback changed without refresh");

   property p_refresh;
      @(posedge clk_i) disable iff (backup_uvlo_i)
      read_refresh_request_i |=> r_q.rback == $past(r_q.active);
   endproperty
   a_refresh: assert property (p_refresh)
      else $error("refresh did not copy active");

   property p_uvlo;
      @(posedge clk_i) backup_uvlo_i |-> r_q == '0;
   endproperty
   a_uvlo: assert property (p_uvlo)
      else $error("registers not cleared by undervoltage");

   // bus side answers in the cycle after the request is taken
   property p_rvalid;
      @(posedge clk_i) disable iff (sys_rst_i)
      req_i.rd |=> rvalid_o;
   endproperty
   a_rvalid: assert property (p_rvalid)
      else $error("read not answered");

   property p_no_rvalid;
      @(posedge clk_i) disable iff (sys_rst_i)
      !req_i.rd |=> !rvalid_o;
   endproperty
   a_no_rvalid: assert property (p_no_rvalid)
      else $error("read answer without request");

   // unmapped reads answer with the reset pattern, never stale data
   property p_unmapped;
      @(posedge clk_i) disable iff (sys_rst_i)
      (req_i.rd && decode(req_i.addr) == 4'hF) |=>
      rdata_o == `RTCATM_REG_RESET;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned data");

   property p_read_back;
      @(posedge clk_i) disable iff (sys_rst_i || backup_uvlo_i)
      (req_i.rd && req_i.addr == `RTCATM_A1_MIN_ADDR) |=>
      rdata_o == $past(r_q.rback[0].min);
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("read did not return frozen copy");

   property p_hold_wr;
      @(posedge clk_i) disable iff (backup_uvlo_i)
      (req_i.wr && req_i.addr == `RTCATM_A2_LIVE_H_COUNTER_ADDR) |=>
      r_q.hold[1].live_h_counter == $past(req_i.wdata);
   endproperty
   a_hold_wr: assert property (p_hold_wr)
      else $error("write did not land in holding buffer");

   c_commit: cover property (@(posedge clk_i) write_commit_request_i);
   c_refresh: cover property (@(posedge clk_i) read_refresh_request_i);
   c_read: cover property (@(posedge clk_i) rvalid_o);
endmodule : rtcatm_top
`default_nettype wire
